// ---- logic/wcs_supervisor.sv ----
// Behaviour
// RL1 - setpoint captured outside the allowed range shows error 17.
// RL2 - any front-panel button press clears a displayed error.
// RL3 - setpoint error while programming keeps compensation disabled, code zero.
// RL4 - average idle deviations; correct firing angle at each weld start.
// RL5 - codes 10 to 31 give a tolerance window raising no error inside.
// RL6 - writing the compensation code again re-captures the nominal setpoint.
// RL7 - average below setpoint minus threshold raises error 19.
// RL8 - average above setpoint plus threshold raises error 20.
// RL9 - output code 12: show error 30 line cycles, valve off, continue.
// RL10 - output codes 10, 13, 17: valve on 30 line cycles, continue.
// RL11 - output code 14: error shown, valve on, sequence halted.
// RL12 - clear code 01 erases schedules, 02 erases extended functions.
// RL13 - program mode, enter held, program click erases shown schedule.
// RL14 - program button held at power-up erases extended functions.
// RL15 - back-step mode: each momentary aux closure steps back one schedule.
// RL16 - aux contact held closed shows error 06.
// RL17 - held over 1.5 s returns to first schedule, error 05 flashes.
// RL18 - back-step code 00 makes aux a temperature limit switch input.
// RL19 - retraction output mode uses aux for retraction, no back-step.
// RL20 - open external no-weld input keeps the control in no-weld.
// RL21 - output code 06 turns the valve on half a second at sequence end.
// RL22 - debounce aux and time its closure in line cycles.
`timescale 1ns/1ps
module wcs_supervisor #(
  parameter int LINE_DIV = wcs_pkg::LINE_DIV_CYC
) (
  input  wire logic                   mclk,
  input  wire logic                   reset,
  input  wire logic [wcs_pkg::AW-1:0] paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic [wcs_pkg::NBTN-1:0] btn_pin,
  input  wire logic                   aux_switch_closed,
  input  wire logic                   no_weld_closed,
  input  wire logic [wcs_pkg::VW-1:0] volt_sample,
  input  wire logic                   volt_valid,
  input  wire logic                   weld_busy,
  input  wire logic                   weld_init,
  input  wire logic                   seq_done,
  output logic [12:0]                 fire_correction,
  output logic [7:0]                  err_code,
  output logic                        err_flash,
  output logic                        valve_on,
  output logic                        seq_halt,
  output logic                        no_weld,
  output logic                        temp_limit_open,
  output logic                        back_step,
  output logic                        first_sched,
  output logic                        retract_toggle,
  output logic                        erase_sched_all,
  output logic                        erase_ext,
  output logic                        erase_sched_one
);
  import wcs_pkg::*;

  typedef struct packed {
    logic [4:0]    comp;
    logic [4:0]    po;
    logic [1:0]    bs;
    logic          prg;
    logic [VW-1:0] setpt;
    logic [15:0]   avg;
    logic [12:0]   corr;
    logic [7:0]    err;
    logic          halt;
    logic          valve;
    logic [6:0]    valve_tmr;
    logic [6:0]    err_tmr;
    logic [21:0]   div_cnt;
    logic          line_en;
    logic [6:0]    bs_cnt;
    logic [2:0]    pu_cnt;
    logic          pu_done;
    logic [NBTN-1:0] prev_btn;
    logic          prev_aux;
    logic          no_weld;
    logic          back;
    logic          first;
    logic          retract;
    logic          er_all;
    logic          er_ext;
    logic          er_one;
    logic          acc;
    logic [31:0]   rdata;
    logic          slverr;
  } wcs_state_t;

  wcs_state_t s;
  wcs_state_t n;
  logic [NBTN-1:0] btn_s;
  logic            aux_s;
  logic            nw_s;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  wcs_sync3 #(.WIDTH(NBTN + 2)) u_sync (
    .mclk  (mclk),
    .reset (reset),
    .din   ({btn_pin, aux_switch_closed, no_weld_closed}),
    .dout  ({btn_s, aux_s, nw_s})
  );

  // threshold percent for window codes, paired monitor/compensate codes
  function automatic logic [5:0] wcs_pct(input logic [4:0] code);
    logic [3:0] idx;
    idx = 4'((code - COMP_WIN_LO) >> 1);
    case (idx)
      4'h0:    wcs_pct = 6'h03;
      4'h1:    wcs_pct = 6'h05;
      default: wcs_pct = {2'b00, idx} * 6'h05;
    endcase
  endfunction

  logic          btn_press;
  logic          comp_en;
  logic          monitor;
  logic          bs_mode;
  logic          rt_mode;
  logic [VW-1:0] avg_v;
  logic [VW-1:0] thr;
  logic [VW:0]   win_lo;
  logic [VW:0]   win_hi;
  logic          volt_low;
  logic          volt_high;
  logic [16:0]   diff;
  logic [4:0]    wr_comp;
  logic          mapped;

  always_comb begin
    btn_press = |(btn_s & ~s.prev_btn);
    avg_v     = s.avg[15:4];
    comp_en   = (s.comp != 5'h00 && s.comp <= COMP_OLD_HI)
             || (s.comp >= COMP_WIN_LO && !s.comp[0]);
    monitor   = s.comp >= COMP_WIN_LO;
    // retraction owns the aux input, so back-step stays off there
    rt_mode   = s.po == PO_RETRACT;                               // [RL19]
    bs_mode   = s.bs == BS_BACKSTEP && !rt_mode;                  // [RL15]
    // percent scaled by 41/4096, close enough to 1/100 for a window
    thr       = VW'(({12'h000, s.setpt} * {18'h00000, wcs_pct(s.comp)} * 30'd41) >> 12);
    win_lo    = {1'b0, s.setpt} - {1'b0, thr};
    win_hi    = {1'b0, s.setpt} + {1'b0, thr};
    volt_low  = monitor && !win_lo[VW] && {1'b0, avg_v} < win_lo;  // [RL5] [RL7]
    volt_high = monitor && {1'b0, avg_v} > win_hi;                // [RL5] [RL8]
    diff      = {1'b0, volt_sample, 4'h0} - {1'b0, s.avg};
    wr_comp   = pwdata[CTRL_COMP_LSB +: 5];
    mapped    = paddr == OFF_CTRL || paddr == OFF_CLEAR || paddr == OFF_STAT
             || paddr == OFF_VOLT;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    n          = s;
    n.line_en  = 1'b0;
    n.back     = 1'b0;
    n.first    = 1'b0;
    n.retract  = 1'b0;
    n.er_all   = 1'b0;
    n.er_ext   = 1'b0;
    n.er_one   = 1'b0;
    n.prev_btn = btn_s;
    n.prev_aux = aux_s;
    n.no_weld  = !nw_s;                                           // [RL20]

    if (s.div_cnt == 22'(LINE_DIV - 1)) begin
      n.div_cnt = '0;
      n.line_en = 1'b1;
    end else begin
      n.div_cnt = s.div_cnt + 22'h1;
    end

    // power-up strap: program button sampled once inputs settle
    if (!s.pu_done) begin
      n.pu_cnt = s.pu_cnt + 3'h1;
      if (s.pu_cnt == 3'(PU_SETTLE)) begin
        n.pu_done = 1'b1;
        n.er_ext  = btn_s[BTN_PRG];                               // [RL14]
      end
    end else if (btn_press) begin
      // clear first so that any event below in this cycle wins
      n.err  = ERR_NONE;                                          // [RL2]
      n.halt = 1'b0;
      if (s.valve_tmr == 7'h00) begin
        n.valve = 1'b0;
      end
      if (s.prg && btn_s[BTN_ENT] && btn_s[BTN_PRG] && !s.prev_btn[BTN_PRG]) begin
        n.er_one = 1'b1;                                          // [RL13]
      end
    end

    // idle averaging, 1/16 exponential weight
    if (volt_valid && !weld_busy) begin
      n.avg = 16'({1'b0, s.avg} + 17'($signed(diff) >>> 4));     // [RL4]
    end

    if (s.line_en && s.valve_tmr != 7'h00) begin
      n.valve_tmr = s.valve_tmr - 7'h01;
      if (s.valve_tmr == 7'h01) begin
        n.valve = 1'b0;
      end
    end
    if (s.line_en && s.err_tmr != 7'h00) begin
      n.err_tmr = s.err_tmr - 7'h01;
      if (s.err_tmr == 7'h01 && (s.err == ERR_V_LOW || s.err == ERR_V_HIGH)) begin
        n.err = ERR_NONE;                                         // [RL9]
      end
    end

    if (weld_init) begin
      if (comp_en) begin
        n.corr = 13'({1'b0, s.setpt} - {1'b0, avg_v});            // [RL4]
      end
      if (volt_low || volt_high) begin
        n.err = volt_low ? ERR_V_LOW : ERR_V_HIGH;                // [RL7] [RL8]
        case (s.po)
          PO_FLASH: begin
            n.err_tmr = 7'(VALVE_CYC);                            // [RL9]
          end
          PO_ERR_ANY, PO_FLASH_V3, PO_MINOR: begin
            n.valve     = 1'b1;                                   // [RL10]
            n.valve_tmr = 7'(VALVE_CYC);
          end
          PO_BREAK: begin
            n.valve = 1'b1;                                       // [RL11]
            n.halt  = 1'b1;
          end
          default: begin
          end
        endcase
      end
    end

    if (seq_done && s.po == PO_EOS) begin
      n.valve     = 1'b1;                                         // [RL21]
      n.valve_tmr = 7'(VALVE_CYC);
    end

    // aux input: back-step, retraction or temperature limit
    if (rt_mode && aux_s && !s.prev_aux) begin
      n.retract = 1'b1;                                           // [RL19]
    end
    if (bs_mode && aux_s) begin
      if (s.line_en && s.bs_cnt != 7'(LONG_CYC)) begin
        n.bs_cnt = s.bs_cnt + 7'h01;                              // [RL22]
        if (s.bs_cnt == 7'(LONG_CYC - 1)) begin
          n.first = 1'b1;                                         // [RL17]
        end
      end
      if (s.bs_cnt == 7'(LONG_CYC)) begin
        n.err = ERR_BS_LONG;                                      // [RL17]
      end else if (s.bs_cnt >= 7'(STUCK_CYC)) begin
        n.err = ERR_BS_HELD;                                      // [RL16]
      end
    end else begin
      n.bs_cnt = 7'h00;
      // a closure that ends before any line-cycle tick never counts
      if (bs_mode && s.prev_aux && s.bs_cnt != 7'h00 && s.bs_cnt < 7'(STUCK_CYC)) begin
        n.back = 1'b1;                                            // [RL15] [RL22]
      end
      // a fresh error raised in this cycle must not be wiped
      if (n.err == ERR_BS_LONG) begin
        n.err = ERR_NONE;                                         // [RL17]
      end
    end

    // apb slave: read data latched in setup, write at the access edge
    if (psel && !penable) begin
      n.acc    = 1'b1;
      n.slverr = !mapped;
      n.rdata  = 32'h0000_0000;
      if (paddr == OFF_CTRL) begin
        n.rdata = {7'h00, s.prg, 6'h00, s.bs, 3'h0, s.po, 3'h0, s.comp};
      end else if (paddr == OFF_STAT) begin
        n.rdata = {4'h0, avg_v, 4'h0, comp_en, s.no_weld, s.halt, s.valve, s.err};
      end else if (paddr == OFF_VOLT) begin
        n.rdata = {3'h0, s.corr, 4'h0, s.setpt};
      end
    end else if (psel && penable && s.acc) begin
      n.acc = 1'b0;
      if (pwrite && paddr == OFF_CTRL) begin
        n.po   = pwdata[CTRL_PO_LSB +: 5];
        n.bs   = pwdata[CTRL_BS_LSB +: 2];                        // [RL18]
        n.prg  = pwdata[CTRL_PRG_BIT];
        n.comp = wr_comp;
        if (wr_comp != 5'h00) begin
          n.setpt = avg_v;                                        // [RL6]
          if (avg_v < SP_MIN || avg_v > SP_MAX) begin
            n.err  = ERR_SETPT;                                   // [RL1]
            n.comp = 5'h00;                                       // [RL3]
          end
        end
      end else if (pwrite && paddr == OFF_CLEAR && s.prg) begin
        n.er_all = pwdata[1:0] == CLR_SCHED;                      // [RL12]
        n.er_ext = pwdata[1:0] == CLR_EXT;                        // [RL12]
      end
    end else begin
      n.acc = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign pready          = s.acc;
  assign prdata          = s.rdata;
  assign pslverr         = s.slverr;
  assign fire_correction = s.corr;
  assign err_code        = s.err;
  assign err_flash       = s.err == ERR_BS_LONG;
  assign valve_on        = s.valve;
  assign seq_halt        = s.halt;
  assign no_weld         = s.no_weld;
  assign temp_limit_open = !bs_mode && !rt_mode && !aux_s;        // [RL18]
  assign back_step       = s.back;
  assign first_sched     = s.first;
  assign retract_toggle  = s.retract;
  assign erase_sched_all = s.er_all;
  assign erase_ext       = s.er_ext;
  assign erase_sched_one = s.er_one;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence volt_err_s;
    weld_init && (volt_low || volt_high);
  endsequence
  sequence ctrl_wr_s;
    psel && penable && pready && pwrite && paddr == OFF_CTRL;
  endsequence

  setpt_err_a: assert property (ctrl_wr_s ##0 (pwdata[4:0] != 5'h00
    && (avg_v < SP_MIN || avg_v > SP_MAX)) |=> err_code == ERR_SETPT && s.comp == 5'h00) // [RL1] [RL3]
    else $error("setpoint error not flagged");
  btn_clear_a: assert property (s.pu_done && btn_press && !weld_init && !(bs_mode && aux_s)
    |=> err_code == ERR_NONE) // [RL2]
    else $error("button did not clear error");
  setpt_capture_a: assert property (ctrl_wr_s ##0 pwdata[4:0] != 5'h00
    |=> s.setpt == $past(avg_v)) // [RL6]
    else $error("setpoint not re-captured");
  low_window_a: assert property (volt_err_s ##0 volt_low |=> err_code == ERR_V_LOW) // [RL7]
    else $error("low window error missing");
  high_window_a: assert property (volt_err_s ##0 !volt_low |=> err_code == ERR_V_HIGH) // [RL8]
    else $error("high window error missing");
  flash_valve_a: assert property (volt_err_s ##0 s.po == PO_FLASH && !valve_on
    |=> !valve_on && s.err_tmr == 7'(VALVE_CYC)) // [RL9]
    else $error("code 12 reaction wrong");
  pulse_valve_a: assert property (volt_err_s ##0 s.po == PO_MINOR
    |=> valve_on && s.valve_tmr == 7'(VALVE_CYC)) // [RL10]
    else $error("valve pulse not started");
  break_halt_a: assert property (volt_err_s ##0 s.po == PO_BREAK |=> seq_halt && valve_on) // [RL11]
    else $error("code 14 did not halt");
  long_hold_a: assert property (first_sched |-> bs_mode ##1 (err_flash || !aux_s)) // [RL17]
    else $error("long hold not flagged");
  no_weld_a: assert property (!nw_s |=> no_weld) // [RL20]
    else $error("no-weld not asserted");
  back_pulse_a: assert property (back_step |-> !aux_s && $past(s.bs_cnt) != 7'h00 ##1 !back_step) // [RL15] [RL22]
    else $error("back-step pulse malformed");
endmodule

// ---- logic/wcs_sync3.sv ----
`timescale 1ns/1ps
module wcs_sync3 #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  // a bit changes only once stages two and three agree
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s1   <= '0;
      s2   <= '0;
      s3   <= '0;
      dout <= '0;
    end else begin
      s1   <= din;
      s2   <= s1;
      s3   <= s2;
      dout <= (s2 & ~(s2 ^ s3)) | (dout & (s2 ^ s3));
    end
  end
endmodule

// ---- pkg/wcs_pkg.sv ----
package wcs_pkg;
  // ---------------------------------------------------------------
  // clock and line timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ       = 200_000_000;
  localparam int LINE_HZ      = 60;
  localparam int LINE_DIV_CYC = CLK_HZ / LINE_HZ;
  localparam int VALVE_MS     = 500;
  localparam int VALVE_CYC    = VALVE_MS * LINE_HZ / 1000;
  localparam int STUCK_MS     = 500;
  localparam int STUCK_CYC    = STUCK_MS * LINE_HZ / 1000;
  localparam int LONG_MS      = 1500;
  localparam int LONG_CYC     = LONG_MS * LINE_HZ / 1000;
  localparam int PU_SETTLE    = 7;
  // ---------------------------------------------------------------
  // widths and register map
  // ---------------------------------------------------------------
  localparam int VW      = 12;
  localparam int AW      = 8;
  localparam int NBTN    = 4;
  localparam int BTN_ENT = 0;
  localparam int BTN_PRG = 1;
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_CLEAR = 8'h04;
  localparam logic [7:0] OFF_STAT  = 8'h08;
  localparam logic [7:0] OFF_VOLT  = 8'h0c;
  localparam int CTRL_COMP_LSB = 0;
  localparam int CTRL_PO_LSB   = 8;
  localparam int CTRL_BS_LSB   = 16;
  localparam int CTRL_PRG_BIT  = 24;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // ---------------------------------------------------------------
  // codes
  // ---------------------------------------------------------------
  localparam logic [7:0] ERR_NONE    = 8'h00;
  localparam logic [7:0] ERR_BS_LONG = 8'h05;
  localparam logic [7:0] ERR_BS_HELD = 8'h06;
  localparam logic [7:0] ERR_SETPT   = 8'h11;
  localparam logic [7:0] ERR_V_LOW   = 8'h13;
  localparam logic [7:0] ERR_V_HIGH  = 8'h14;
  localparam logic [4:0] PO_EOS      = 5'h06;
  localparam logic [4:0] PO_RETRACT  = 5'h08;
  localparam logic [4:0] PO_ERR_ANY  = 5'h0a;
  localparam logic [4:0] PO_FLASH    = 5'h0c;
  localparam logic [4:0] PO_FLASH_V3 = 5'h0d;
  localparam logic [4:0] PO_BREAK    = 5'h0e;
  localparam logic [4:0] PO_MINOR    = 5'h11;
  localparam logic [4:0] COMP_WIN_LO = 5'h0a;
  localparam logic [4:0] COMP_OLD_HI = 5'h05;
  localparam logic [1:0] BS_BACKSTEP = 2'h1;
  localparam logic [1:0] CLR_SCHED   = 2'h1;
  localparam logic [1:0] CLR_EXT     = 2'h2;
  localparam logic [VW-1:0] SP_MIN   = 12'h200;
  localparam logic [VW-1:0] SP_MAX   = 12'hf00;
endpackage

// ---- verification/tb.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// bench for the supervisory block
// ----------------------------------------
module tb;
  import wcs_pkg::*;
  localparam int LD = 8;
  logic          mclk = 1'b0;
  logic          reset = 1'b1;
  logic [AW-1:0] paddr = '0;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [31:0]   pwdata = '0;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic [3:0]    btn_pin;
  logic          aux_switch_closed;
  logic          no_weld_closed;
  logic [VW-1:0] volt_sample = '0;
  logic          volt_valid = 1'b0;
  logic          weld_busy = 1'b0;
  logic          weld_init = 1'b0;
  logic          seq_done = 1'b0;
  logic [12:0]   fire_correction;
  logic [7:0]    err_code;
  logic          err_flash, valve_on, seq_halt, no_weld, temp_limit_open;
  logic          back_step, first_sched, retract_toggle;
  logic          erase_sched_all, erase_ext, erase_sched_one;
  logic [3:0]    btn_req = 4'h2;
  logic          aux_req = 1'b0;
  logic          nw_req = 1'b1;
  int            error_cnt = 0;
  int            num_checks = 0;
  logic [8:0]    exp_q[$];
  logic [7:0]    prev_err = 8'h00;
  logic [5:0]    pv;
  logic [31:0]   rd;
  logic          se;
  logic [4:0]    pos[5] = '{PO_FLASH, PO_ERR_ANY, PO_FLASH_V3, PO_MINOR, PO_BREAK};
  logic [12:0]   dfc;

  always #2.5 mclk = ~mclk;

  wcs_supervisor #(.LINE_DIV(LD)) i_wcs_supervisor (.mclk(mclk), .reset(reset),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .btn_pin(btn_pin),
    .aux_switch_closed(aux_switch_closed), .no_weld_closed(no_weld_closed),
    .volt_sample(volt_sample), .volt_valid(volt_valid), .weld_busy(weld_busy),
    .weld_init(weld_init), .seq_done(seq_done), .fire_correction(fire_correction),
    .err_code(err_code), .err_flash(err_flash), .valve_on(valve_on), .seq_halt(seq_halt),
    .no_weld(no_weld), .temp_limit_open(temp_limit_open), .back_step(back_step),
    .first_sched(first_sched), .retract_toggle(retract_toggle),
    .erase_sched_all(erase_sched_all), .erase_ext(erase_ext),
    .erase_sched_one(erase_sched_one));

  wcs_panel_model i_wcs_panel_model (.mclk(mclk), .btn_req(btn_req), .aux_req(aux_req),
    .nw_req(nw_req), .btn_pin(btn_pin), .aux_switch_closed(aux_switch_closed),
    .no_weld_closed(no_weld_closed));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_evt(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: event %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk) penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  function automatic logic [31:0] cw(logic [4:0] c, logic [4:0] p, logic [1:0] b, logic g);
    return (32'(c) << CTRL_COMP_LSB) | (32'(p) << CTRL_PO_LSB) | (32'(b) << CTRL_BS_LSB)
      | (32'(g) << CTRL_PRG_BIT);
  endfunction

  task automatic ticks(input int n);
    repeat (n * LD) @(posedge mclk);
  endtask

  task automatic press(input int b);
    btn_req[b] <= 1'b1;
    repeat (20) @(posedge mclk);
    btn_req[b] <= 1'b0;
    repeat (20) @(posedge mclk);
  endtask

  task automatic feed(input logic [VW-1:0] b, input int n);
    repeat (n) begin
      volt_sample <= b + VW'($urandom_range(0, 7));
      volt_valid <= 1'b1;
      @(posedge mclk) volt_valid <= 1'b0;
      @(posedge mclk);
    end
  endtask

  task automatic pulse(input logic is_done);
    if (is_done) seq_done <= 1'b1;
    else weld_init <= 1'b1;
    @(posedge mclk);
    seq_done <= 1'b0;
    weld_init <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  task automatic ev(input logic k, input logic [7:0] v);
    exp_q.push_back({k, v});
  endtask

  // ----------------------------------------
  // result watcher: pulses and new error codes
  // ----------------------------------------
  task automatic take(input logic [8:0] got);
    if (exp_q.size() == 0) check_evt(got, 9'h1ff);
    else check_evt(got, exp_q.pop_front());
  endtask

  always @(posedge mclk) begin
    if (!reset) begin
      pv = {erase_sched_one, erase_ext, erase_sched_all, retract_toggle, first_sched, back_step};
      if (pv !== 6'h00) take({3'b100, pv});
      if (err_code !== prev_err && err_code !== 8'h00) take({1'b0, err_code});
      prev_err = err_code;
    end
  end

  initial begin
    #400000;
    error_cnt++;
    tally_and_finish();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h99a346e9));
    ev(1'b1, 8'h10);
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    repeat (30) @(posedge mclk);
    btn_req <= 4'h0;
    repeat (20) @(posedge mclk);
    apb(1'b0, OFF_CTRL, 32'h0);
    check_val(rd, CTRL_RESET);
    apb(1'b0, 8'h10, 32'h0);
    check_val({30'h0, se, rd[0]}, 32'h2);
    nw_req <= 1'b0;
    ticks(2);
    check_val(32'(no_weld), 32'h1);
    nw_req <= 1'b1;
    ticks(2);
    check_val(32'(no_weld), 32'h0);
    check_val(32'(temp_limit_open), 32'h1);
    aux_req <= 1'b1;
    ticks(3);
    check_val(32'(temp_limit_open), 32'h0);
    aux_req <= 1'b0;
    ticks(3);
    // setpoint captured far below the legal range
    feed(12'h100, 160);
    ev(1'b0, ERR_SETPT);
    apb(1'b1, OFF_CTRL, cw(COMP_WIN_LO, PO_FLASH, 2'h0, 1'b0));
    ticks(1);
    apb(1'b0, OFF_CTRL, 32'h0);
    check_val(32'(rd[4:0]), 32'h0);
    press(BTN_ENT);
    check_val(32'(err_code), 32'h0);
    // window reactions; every rewrite re-captures, so the window follows
    feed(12'h800, 160);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, OFF_CTRL, cw(COMP_WIN_LO, pos[i], 2'h0, 1'b0));
      pulse(1'b0);
      check_val(32'(err_code), 32'h0);
      feed((i % 2 == 0) ? 12'h600 : 12'h800, 160);
      weld_busy <= 1'b1;
      feed(12'h100, 40);                                // ignored while busy
      weld_busy <= 1'b0;
      ev(1'b0, (i % 2 == 0) ? ERR_V_LOW : ERR_V_HIGH);
      pulse(1'b0);
      check_val(32'(valve_on), 32'(pos[i] != PO_FLASH));
      check_val(32'(seq_halt), 32'(pos[i] == PO_BREAK));
      dfc = fire_correction - 13'h200;
      if (i == 0) check_val(32'(dfc < 13'h10 || dfc > 13'h1ff0), 32'h1);
      ticks(25);
      check_val(32'(valve_on), 32'(pos[i] != PO_FLASH));
      check_val(32'(err_code == 8'h00), 32'h0);
      ticks(10);
      if (pos[i] != PO_BREAK) check_val(32'(valve_on), 32'h0);
      if (pos[i] == PO_FLASH) check_val(32'(err_code), 32'h0);
      press(BTN_ENT);
      check_val({err_code, 23'h0, seq_halt}, 32'h0);
    end
    apb(1'b1, OFF_CTRL, cw(5'h0, PO_EOS, 2'h0, 1'b0));
    pulse(1'b1);
    check_val(32'(valve_on), 32'h1);
    ticks(25);
    check_val(32'(valve_on), 32'h1);
    ticks(10);
    check_val(32'(valve_on), 32'h0);
    // back-step: a click, then a long hold
    apb(1'b1, OFF_CTRL, cw(5'h0, 5'h0, BS_BACKSTEP, 1'b0));
    ticks(1);
    check_val(32'(temp_limit_open), 32'h0);
    ev(1'b1, 8'h01);
    aux_req <= 1'b1;
    ticks(3);
    aux_req <= 1'b0;
    ticks(3);
    ev(1'b0, ERR_BS_HELD);
    ev(1'b1, 8'h02);
    ev(1'b0, ERR_BS_LONG);
    aux_req <= 1'b1;
    ticks(100);
    check_val({err_code, 23'h0, err_flash}, {ERR_BS_LONG, 24'h1});
    aux_req <= 1'b0;
    ticks(3);
    press(BTN_ENT);
    apb(1'b1, OFF_CTRL, cw(5'h0, PO_RETRACT, BS_BACKSTEP, 1'b0));
    ev(1'b1, 8'h04);
    aux_req <= 1'b1;
    ticks(3);
    aux_req <= 1'b0;
    ticks(3);
    // erase functions; clear is refused outside program mode
    apb(1'b1, OFF_CLEAR, 32'(CLR_SCHED));
    apb(1'b1, OFF_CTRL, cw(5'h0, 5'h0, 2'h0, 1'b1));
    ev(1'b1, 8'h08);
    apb(1'b1, OFF_CLEAR, 32'(CLR_SCHED));
    ticks(1);
    ev(1'b1, 8'h10);
    apb(1'b1, OFF_CLEAR, 32'(CLR_EXT));
    ticks(1);
    ev(1'b1, 8'h20);
    btn_req[BTN_ENT] <= 1'b1;
    repeat (20) @(posedge mclk);
    press(BTN_PRG);
    btn_req[BTN_ENT] <= 1'b0;
    ticks(5);
    check_val(32'(exp_q.size()), 32'h0);
    tally_and_finish();
  end
endmodule

// ---- verification/wcs_panel_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// operator buttons, contacts and plc lines
// ----------------------------------------
module wcs_panel_model (
  input  wire logic       mclk,
  input  wire logic [3:0] btn_req,
  input  wire logic       aux_req,
  input  wire logic       nw_req,
  output logic      [3:0] btn_pin,
  output logic            aux_switch_closed,
  output logic            no_weld_closed
);
  logic [3:0] btn_q = 4'h0;
  logic       aux_q = 1'b0;
  logic       aux_d = 1'b0;
  logic       nw_q  = 1'b1;
  logic [2:0] chat  = 3'h0;
  assign btn_pin           = btn_q;
  assign aux_switch_closed = aux_q;
  assign no_weld_closed    = nw_q;
  // real contacts bounce on make; the device has to filter this
  always @(posedge mclk) begin
    btn_q <= btn_req;
    nw_q  <= nw_req;
    aux_d <= aux_req;
    if (aux_req && !aux_d) begin
      chat <= 3'h4;
    end
    if (chat != 3'h0) begin
      aux_q <= chat[0];
      chat  <= chat - 3'h1;
    end else begin
      aux_q <= aux_req;              // follows the requested contact state once the chatter ends
    end
  end
endmodule
